// ### design/comp_cfg_pkg.sv
// Constants, field layout and helpers for the loop compensation register
package comp_cfg_pkg;

  // Command and framing
  localparam logic [7:0] CMD_CODE     = 8'hb1;
  localparam int         VALUE_BYTES  = 5;
  localparam int         VALUE_WIDTH  = 40;
  localparam logic [7:0] BYTE_COUNT   = 8'h05;
  localparam logic [7:0] RD_PAD_BYTE  = 8'hff;
  localparam logic [2:0] LAST_IDX     = 3'h5;
  localparam logic [2:0] DONE_IDX     = 3'h6;
  localparam logic [2:0] SAT_IDX      = 3'h7;

  // Value held before the start-up load arrives
  localparam logic [39:0] RESET_VALUE = 40'h00_0000_0000;

  // Field positions
  localparam int CZI_LO_MSB = 39;
  localparam int CZI_LO_LSB = 38;
  localparam int CPI_MSB    = 37;
  localparam int CPI_LSB    = 33;
  localparam int CZI_MUL    = 32;
  localparam int RVI_MSB    = 31;
  localparam int RVI_LSB    = 26;
  localparam int CZI_HI_MSB = 25;
  localparam int CZI_HI_LSB = 24;
  localparam int CZV_LO_MSB = 23;
  localparam int CZV_LO_LSB = 22;
  localparam int CPV_MSB    = 21;
  localparam int CPV_LSB    = 17;
  localparam int RSV_B16    = 16;
  localparam int RVV_MSB    = 15;
  localparam int RVV_LSB    = 10;
  localparam int CZV_HI_MSB = 9;
  localparam int CZV_HI_LSB = 8;
  localparam int RSV_HI_MSB = 7;
  localparam int RSV_HI_LSB = 6;
  localparam int GMV_MSB    = 5;
  localparam int GMV_LSB    = 4;
  localparam int RSV_LO_MSB = 3;
  localparam int RSV_LO_LSB = 2;
  localparam int GMI_MSB    = 1;
  localparam int GMI_LSB    = 0;

  // Split integrator codes: high pair and low pair sit apart
  function automatic logic [3:0] join_code(input logic [1:0] hi,
                                           input logic [1:0] lo);
    join_code = {hi, lo};
  endfunction

endpackage

// ### design/wr_block_collect.sv
// Collects a block write: count byte then five value bytes
`timescale 1ns/1ps
module wr_block_collect (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic        ce,
  // Byte stream
  input  wire logic        begin_write,
  input  wire logic        byte_valid,
  input  wire logic [7:0]  byte_data,
  input  wire logic        end_write,
  // Result
  output logic             word_valid,
  output logic [39:0]      word_data,
  output logic             frame_error
);
  logic        active_reg, active_next;
  logic        bad_reg, bad_next;
  logic [2:0]  idx_reg, idx_next;
  logic [39:0] word_reg, word_next;
  logic        ok_reg, ok_next;
  logic        err_reg, err_next;
  logic [2:0]  lane;

  // Next byte position; first value byte is the least significant
  always_comb begin
    active_next = active_reg;
    bad_next    = bad_reg;
    idx_next    = idx_reg;
    word_next   = word_reg;
    ok_next     = 1'b0;
    err_next    = 1'b0;
    lane        = idx_reg - 3'h1;
    if (begin_write) begin
      active_next = 1'b1;
      bad_next    = 1'b0;
      idx_next    = 3'h0;
    end else if (active_reg) begin
      if (byte_valid) begin
        if (idx_reg == 3'h0) begin
          bad_next = (byte_data != comp_cfg_pkg::BYTE_COUNT);
        end else if (idx_reg <= comp_cfg_pkg::LAST_IDX) begin
          word_next[{lane, 3'h0} +: 8] = byte_data;
        end else begin
          bad_next = 1'b1; // Too many bytes
        end
        if (idx_reg != comp_cfg_pkg::SAT_IDX) begin
          idx_next = idx_reg + 3'h1;
        end
      end
      if (end_write) begin
        active_next = 1'b0;
        // A short or padded frame must not change the register
        if (!bad_next && idx_next == comp_cfg_pkg::DONE_IDX) begin
          ok_next = 1'b1;
        end else begin
          err_next = 1'b1;
        end
      end
    end
  end

  // Registers only
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      active_reg <= 1'b0;
      bad_reg    <= 1'b0;
      idx_reg    <= 3'h0;
      word_reg   <= 40'h00_0000_0000;
      ok_reg     <= 1'b0;
      err_reg    <= 1'b0;
    end else if (ce) begin
      active_reg <= active_next;
      bad_reg    <= bad_next;
      idx_reg    <= idx_next;
      word_reg   <= word_next;
      ok_reg     <= ok_next;
      err_reg    <= err_next;
    end
  end

  assign word_valid  = ok_reg;
  assign word_data   = word_reg;
  assign frame_error = err_reg;
endmodule

// ### design/rd_block_serve.sv
// Serves a block read: count byte then five value bytes
`timescale 1ns/1ps
module rd_block_serve (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic        ce,
  // Snapshot and byte requests
  input  wire logic        load,
  input  wire logic [39:0] load_data,
  input  wire logic        byte_req,
  // Answer
  output logic [7:0]       byte_data,
  output logic             byte_valid
);
  logic [39:0] snap_reg, snap_next;
  logic [2:0]  idx_reg, idx_next;
  logic [7:0]  dat_reg, dat_next;
  logic        vld_reg, vld_next;
  logic [2:0]  lane;

  // Snapshot keeps the bytes coherent if a write lands mid-read
  always_comb begin
    snap_next = snap_reg;
    idx_next  = idx_reg;
    dat_next  = dat_reg;
    vld_next  = 1'b0;
    lane      = idx_reg - 3'h1;
    if (load) begin
      snap_next = load_data;
      idx_next  = 3'h0;
    end else if (byte_req) begin
      vld_next = 1'b1;
      if (idx_reg == 3'h0) begin
        dat_next = comp_cfg_pkg::BYTE_COUNT;
      end else if (idx_reg <= comp_cfg_pkg::LAST_IDX) begin
        dat_next = snap_reg[{lane, 3'h0} +: 8];
      end else begin
        dat_next = comp_cfg_pkg::RD_PAD_BYTE;
      end
      if (idx_reg != comp_cfg_pkg::SAT_IDX) begin
        idx_next = idx_reg + 3'h1;
      end
    end
  end

  // Registers only
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      snap_reg <= 40'h00_0000_0000;
      idx_reg  <= 3'h0;
      dat_reg  <= 8'h00;
      vld_reg  <= 1'b0;
    end else if (ce) begin
      snap_reg <= snap_next;
      idx_reg  <= idx_next;
      dat_reg  <= dat_next;
      vld_reg  <= vld_next;
    end
  end

  assign byte_data  = dat_reg;
  assign byte_valid = vld_reg;
endmodule

// ### design/comp_cfg_regbank.sv
// Loop compensation register: stored copy, applied copy, load control
`timescale 1ns/1ps
module comp_cfg_regbank (
  // Clock, reset, enable
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic        ce,
  // Transaction layer from the management bus engine
  input  wire logic        txn_start,
  input  wire logic [7:0]  txn_cmd,
  input  wire logic        txn_read,
  input  wire logic        wr_byte_valid,
  input  wire logic [7:0]  wr_byte_data,
  input  wire logic        txn_stop,
  input  wire logic        rd_byte_req,
  output logic [7:0]       rd_byte_data,
  output logic             rd_byte_valid,
  // Power and storage status
  input  wire logic        conversion_enabled,
  input  wire logic        restore_all,
  input  wire logic        analog_bias_supply_low,
  input  wire logic        init_ready,
  input  wire logic        strap_detect_bypass,
  input  wire logic [39:0] nvm_value,
  input  wire logic [39:0] strap_value,
  // Control loop selects
  output logic [3:0]       current_integrator_cap_code,
  output logic [4:0]       current_filter_cap_code,
  output logic             current_integrator_cap_doubler,
  output logic [5:0]       current_gain_resistor_code,
  output logic [3:0]       voltage_integrator_cap_code,
  output logic [4:0]       voltage_filter_cap_code,
  output logic [5:0]       voltage_gain_resistor_code,
  output logic [1:0]       voltage_transconductance_code,
  output logic [1:0]       current_transconductance_code,
  // Block status
  output logic             hw_update,
  output logic             update_pending,
  output logic             write_rejected,
  output logic             init_done
);

  typedef enum logic [1:0] {
    ST_INIT,
    ST_RUN,
    ST_BIAS_LOW
  } bank_state_t;

  bank_state_t state_reg, state_next;

  logic [39:0] stored_reg, stored_next;
  logic [39:0] applied_reg, applied_next;
  logic        pend_reg, pend_next;
  logic        upd_reg, upd_next;
  logic        rej_reg, rej_next;
  logic        done_reg, done_next;
  logic        wr_mine_reg, wr_mine_next;

  // Decoded bus events
  logic        hit;
  logic        begin_wr;
  logic        begin_rd;
  logic        wr_valid;
  logic [39:0] wr_word;
  logic        wr_err;
  logic [39:0] load_src;
  logic        load_evt;

  // Only our command code opens a frame; other codes belong elsewhere
  assign hit      = txn_start && (txn_cmd == comp_cfg_pkg::CMD_CODE);
  assign begin_wr = hit && !txn_read && (state_reg == ST_RUN);
  assign begin_rd = hit && txn_read;

  // Byte collector for block writes
  wr_block_collect u_collect (
    .sys_clk     (sys_clk),
    .rstn        (rstn),
    .ce          (ce),
    .begin_write (begin_wr),
    .byte_valid  (wr_byte_valid && wr_mine_reg),
    .byte_data   (wr_byte_data),
    .end_write   (txn_stop && wr_mine_reg),
    .word_valid  (wr_valid),
    .word_data   (wr_word),
    .frame_error (wr_err)
  );

  // Byte server for block reads, fed from the stored copy
  rd_block_serve u_serve (
    .sys_clk    (sys_clk),
    .rstn       (rstn),
    .ce         (ce),
    .load       (begin_rd),
    .load_data  (stored_reg),
    .byte_req   (rd_byte_req),
    .byte_data  (rd_byte_data),
    .byte_valid (rd_byte_valid)
  );

  // Reload source: strap detection when selected, else EEPROM copy
  assign load_src = strap_detect_bypass ? strap_value
                                        : nvm_value;

  // Restore command reloads while running; a host must have stored
  // the value first or the old one comes back
  assign load_evt = restore_all && (state_reg == ST_RUN);

  // Frame ownership: bytes between start and stop of our command
  always_comb begin
    wr_mine_next = wr_mine_reg;
    if (txn_start) begin
      wr_mine_next = begin_wr;
    end else if (txn_stop) begin
      wr_mine_next = 1'b0;
    end
  end

  // Power state: start-up load, run, and bias supply dropout
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_INIT: begin
        if (!analog_bias_supply_low && init_ready) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (analog_bias_supply_low) begin
          state_next = ST_BIAS_LOW;
        end
      end
      ST_BIAS_LOW: begin
        // Recovery waits for the storage to be read again
        if (!analog_bias_supply_low && init_ready) begin
          state_next = ST_RUN;
        end
      end
    endcase
  end

  // Stored and applied copies
  always_comb begin
    stored_next  = stored_reg;
    applied_next = applied_reg;
    upd_next     = 1'b0;
    rej_next     = 1'b0;
    done_next    = done_reg;
    if (state_next == ST_RUN && state_reg != ST_RUN) begin
      // Start-up or bias recovery: both copies take the source
      stored_next  = load_src;
      applied_next = load_src;
      upd_next     = 1'b1;
      done_next    = 1'b1;
    end else if (load_evt) begin
      // Restore beats a write in the same cycle, as the reload is
      // the newer request from the host's point of view
      stored_next  = load_src;
      applied_next = load_src;
      upd_next     = 1'b1;
    end else if (wr_valid && state_reg == ST_RUN) begin
      stored_next = wr_word;
      if (!conversion_enabled) begin
        applied_next = wr_word;
        upd_next     = 1'b1;
      end
    end
    if (wr_err) begin
      rej_next = 1'b1;
    end
    pend_next = (stored_next != applied_next);
  end

  // Registers only
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      state_reg   <= ST_INIT;
      stored_reg  <= comp_cfg_pkg::RESET_VALUE;
      applied_reg <= comp_cfg_pkg::RESET_VALUE;
      pend_reg    <= 1'b0;
      upd_reg     <= 1'b0;
      rej_reg     <= 1'b0;
      done_reg    <= 1'b0;
      wr_mine_reg <= 1'b0;
    end else if (ce) begin
      state_reg   <= state_next;
      stored_reg  <= stored_next;
      applied_reg <= applied_next;
      pend_reg    <= pend_next;
      upd_reg     <= upd_next;
      rej_reg     <= rej_next;
      done_reg    <= done_next;
      wr_mine_reg <= wr_mine_next;
    end
  end

  // Current loop selects, taken from the applied copy only
  assign current_integrator_cap_code = comp_cfg_pkg::join_code(
    applied_reg[comp_cfg_pkg::CZI_HI_MSB:comp_cfg_pkg::CZI_HI_LSB],
    applied_reg[comp_cfg_pkg::CZI_LO_MSB:comp_cfg_pkg::CZI_LO_LSB]
  );
  assign current_filter_cap_code =
    applied_reg[comp_cfg_pkg::CPI_MSB:comp_cfg_pkg::CPI_LSB];
  assign current_integrator_cap_doubler =
    applied_reg[comp_cfg_pkg::CZI_MUL];
  assign current_gain_resistor_code =
    applied_reg[comp_cfg_pkg::RVI_MSB:comp_cfg_pkg::RVI_LSB];
  assign current_transconductance_code =
    applied_reg[comp_cfg_pkg::GMI_MSB:comp_cfg_pkg::GMI_LSB];

  // Voltage loop selects
  assign voltage_integrator_cap_code = comp_cfg_pkg::join_code(
    applied_reg[comp_cfg_pkg::CZV_HI_MSB:comp_cfg_pkg::CZV_HI_LSB],
    applied_reg[comp_cfg_pkg::CZV_LO_MSB:comp_cfg_pkg::CZV_LO_LSB]
  );
  assign voltage_filter_cap_code =
    applied_reg[comp_cfg_pkg::CPV_MSB:comp_cfg_pkg::CPV_LSB];
  assign voltage_gain_resistor_code =
    applied_reg[comp_cfg_pkg::RVV_MSB:comp_cfg_pkg::RVV_LSB];
  assign voltage_transconductance_code =
    applied_reg[comp_cfg_pkg::GMV_MSB:comp_cfg_pkg::GMV_LSB];

  // Reserved bits are stored as written and read back; the loop
  // ignores them, so a host that breaks the zero convention only
  // sees its own value echoed

  // Status outputs
  assign hw_update      = upd_reg;
  assign update_pending = pend_reg;
  assign write_rejected = rej_reg;
  assign init_done      = done_reg;

endmodule

// ### testbench/comp_cfg_assertions.sv
// Port checker for the loop compensation register
`timescale 1ns/1ps
module comp_cfg_assertions (
  // Clock and reset
  input wire logic       sys_clk,
  input wire logic       rstn,
  input wire logic       ce,
  // Requests and power status
  input wire logic       rd_byte_req,
  input wire logic       restore_all,
  input wire logic       analog_bias_supply_low,
  input wire logic       init_ready,
  input wire logic       conversion_enabled,
  // Observed outputs
  input wire logic       rd_byte_valid,
  input wire logic [3:0] current_integrator_cap_code,
  input wire logic [3:0] voltage_integrator_cap_code,
  input wire logic [1:0] current_transconductance_code,
  input wire logic       hw_update,
  input wire logic       update_pending,
  input wire logic       write_rejected,
  input wire logic       init_done
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  // Read answers come exactly one cycle after each request
  a_read_answer: assert property (
    ce && rd_byte_req |=> rd_byte_valid)
    else $error("Read request not answered");
  a_read_quiet: assert property (
    ce && !rd_byte_req |=> !rd_byte_valid)
    else $error("Read answer without request");
  // Selects move only with a load; the reset clear is left out
  a_select_hold: assert property (
    $past(rstn) && $changed({current_integrator_cap_code,
    voltage_integrator_cap_code, current_transconductance_code})
    |-> hw_update)
    else $error("Loop selects changed without a load");
  // A load leaves both copies equal
  a_load_settles: assert property (hw_update |-> !update_pending)
    else $error("Pending still set after a load");
  a_reject_quiet: assert property (write_rejected |-> !hw_update)
    else $error("Discarded frame reached the loop");
  a_init_sticky: assert property (init_done |=> init_done)
    else $error("Start-up flag dropped");
  a_init_load: assert property ($rose(init_done) |-> hw_update)
    else $error("Start-up load not applied");
  // A restore reloads on the next edge, whether running or ending a bias dropout
  a_restore_load: assert property (
    ce && init_done && restore_all && init_ready &&
    !analog_bias_supply_low |=> hw_update)
    else $error("Restore did not reload the loop");
  // Only a write while converting leaves a value unapplied
  a_blocked_write: assert property (
    $rose(update_pending) |-> $past(conversion_enabled))
    else $error("Pending rose while not converting");

  c_restore: cover property (hw_update && $past(restore_all));
  c_reject: cover property (write_rejected);
  c_blocked: cover property ($rose(update_pending));
endmodule

// ### testbench/host_model.sv
// Host model: issues block transfers at the transaction layer
`timescale 1ns/1ps
module host_model (
  // Clock
  input  wire logic sys_clk,
  // Transaction requests
  output logic       txn_start,
  output logic [7:0] txn_cmd,
  output logic       txn_read,
  output logic       wr_byte_valid,
  output logic [7:0] wr_byte_data,
  output logic       txn_stop,
  output logic       rd_byte_req
);
  int gap = 0;  // Idle cycles between bytes; nonzero is a slow host

  // Idle bus at time zero
  initial begin
    {txn_start, txn_read, wr_byte_valid, txn_stop, rd_byte_req} = '0;
    txn_cmd = 8'h00;
    wr_byte_data = 8'h00;
  end

  // Drive changes just after the rising edge
  task automatic step();
    @(posedge sys_clk);
    #1;
  endtask

  // Command qualifies the start cycle only, then is scrambled
  task automatic open(input logic [7:0] cmd, input logic rd);
    txn_cmd = cmd;
    txn_read = rd;
    txn_start = 1'b1;
    step();
    txn_start = 1'b0;
    txn_cmd = ~cmd;
  endtask

  // Count byte, then value bytes, least significant first
  task automatic write_block(input logic [7:0] cmd, input logic [7:0] cnt,
                             input logic [39:0] v, input int n);
    logic [47:0] f;
    f = {v, cnt};
    open(cmd, 1'b0);
    for (int i = 0; i <= n; i++) begin
      wr_byte_valid = 1'b1;
      wr_byte_data = f[8*i +: 8];
      step();
      if (gap > 0) begin
        wr_byte_valid = 1'b0;
        wr_byte_data = ~wr_byte_data;  // Released data is not kept
        repeat (gap) step();
      end
    end
    wr_byte_valid = 1'b0;
    txn_stop = 1'b1;
    step();
    txn_stop = 1'b0;
  endtask

  // Seven requests: count, five bytes and one past the end
  task automatic read_block(input logic [7:0] cmd);
    open(cmd, 1'b1);
    repeat (7) begin
      rd_byte_req = 1'b1;
      step();
      if (gap > 0) begin
        rd_byte_req = 1'b0;
        repeat (gap) step();
      end
    end
    rd_byte_req = 1'b0;
    txn_stop = 1'b1;
    step();
    txn_stop = 1'b0;
  endtask
endmodule

// ### testbench/tb_top.sv
// Self-checking bench for the loop compensation register
`timescale 1ns/1ps
module tb_top;
  logic sys_clk, rstn, ce, txn_start, txn_read, wr_byte_valid, txn_stop;
  logic rd_byte_req, rd_byte_valid, conversion_enabled, restore_all;
  logic analog_bias_supply_low, init_ready, strap_detect_bypass;
  logic hw_update, update_pending, write_rejected, init_done;
  logic [7:0] txn_cmd, wr_byte_data, rd_byte_data, eb;
  logic [39:0] nvm_value, strap_value, v, ev;
  logic [3:0] current_integrator_cap_code, voltage_integrator_cap_code;
  logic [4:0] current_filter_cap_code, voltage_filter_cap_code;
  logic [5:0] current_gain_resistor_code, voltage_gain_resistor_code;
  logic [1:0] voltage_transconductance_code, current_transconductance_code;
  logic current_integrator_cap_doubler;
  logic [34:0] sel, es;
  logic [7:0] rd_q[$];
  logic [39:0] hw_q[$];
  int num_errors = 0, comparisons = 0, cycles = 0, rejects = 0;

  comp_cfg_regbank dut (.sys_clk, .rstn, .ce, .txn_start, .txn_cmd,
    .txn_read, .wr_byte_valid, .wr_byte_data, .txn_stop, .rd_byte_req,
    .rd_byte_data, .rd_byte_valid, .conversion_enabled, .restore_all,
    .analog_bias_supply_low, .init_ready, .strap_detect_bypass,
    .nvm_value, .strap_value, .current_integrator_cap_code,
    .current_filter_cap_code, .current_integrator_cap_doubler,
    .current_gain_resistor_code, .voltage_integrator_cap_code,
    .voltage_filter_cap_code, .voltage_gain_resistor_code,
    .voltage_transconductance_code, .current_transconductance_code,
    .hw_update, .update_pending, .write_rejected, .init_done);
  host_model host (.sys_clk, .txn_start, .txn_cmd, .txn_read,
    .wr_byte_valid, .wr_byte_data, .txn_stop, .rd_byte_req);

  assign sel = {current_integrator_cap_code, current_filter_cap_code,
    current_integrator_cap_doubler, current_gain_resistor_code,
    voltage_integrator_cap_code, voltage_filter_cap_code,
    voltage_gain_resistor_code, voltage_transconductance_code,
    current_transconductance_code};

  // Expected selects: split integrator codes joined high pair first
  function automatic logic [34:0] sel_of(input logic [39:0] x);
    return {x[25:24], x[39:38], x[37:33], x[32], x[31:26], x[9:8],
            x[23:22], x[21:17], x[15:10], x[5:4], x[1:0]};
  endfunction

  task automatic check(input string what, input logic [39:0] seen,
                       input logic [39:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("Checks %0d, errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Random value with the reserved bits kept at zero
  function automatic logic [39:0] rnd();
    return 40'({$urandom, $urandom}) & 40'hff_fffe_ff33;
  endfunction

  task automatic expect_read(input logic [39:0] x);
    rd_q.push_back(8'h05);
    for (int i = 0; i < 5; i++) rd_q.push_back(x[8*i +: 8]);
    rd_q.push_back(8'hff);  // Past the end pads
  endtask

  // Write, then let the commit edge pass before anything else
  task automatic wr(input logic [7:0] c, input logic [39:0] x, input int n);
    host.write_block(8'hb1, c, x, n);
    repeat (2) host.step();
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Results are compared against the oldest note as they appear
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      print_verdict();
    end
    if (rd_byte_valid === 1'b1) begin
      eb = (rd_q.size() > 0) ? rd_q.pop_front() : 8'hxx;
      check("read byte", 40'(rd_byte_data), 40'(eb));
    end
    if (hw_update === 1'b1) begin
      ev = (hw_q.size() > 0) ? hw_q.pop_front() : 40'hx;
      es = sel_of(ev);
      check("sel", 40'(sel), 40'(es));
    end
    if (write_rejected === 1'b1) rejects++;
  end

  initial begin
    {rstn, conversion_enabled, restore_all, analog_bias_supply_low} = '0;
    {init_ready, strap_detect_bypass} = 2'h1;
    ce = 1'b1;
    nvm_value = 40'h00_0000_0000;
    strap_value = 40'h00_0000_0000;
    void'($urandom(32'hb0131dad));
    repeat (5) host.step();
    rstn = 1'b1;
    // Reads before start-up return zero
    expect_read(40'h00_0000_0000);
    host.read_block(8'hb1);
    strap_value = rnd();
    nvm_value = rnd();
    hw_q.push_back(strap_value);
    init_ready = 1'b1;
    for (int i = 0; i < 20 && init_done !== 1'b1; i++) host.step();
    check("init_done", 40'(init_done), 40'h1);
    host.step();
    // Conversion off: six writes, with reads after every second one, reach the loop at once
    for (int k = 0; k < 6; k++) begin
      host.gap = k % 3;
      v = rnd();
      hw_q.push_back(v);
      wr(8'h05, v, 5);
      if (k % 2 == 1) begin
        expect_read(v);
        host.read_block(8'hb1);
      end
    end
    // Converting: stored and readable but held from the loop
    conversion_enabled = 1'b1;
    v = rnd();
    expect_read(v);
    wr(8'h05, v, 5);
    host.read_block(8'hb1);
    check("pending", 40'(update_pending), 40'h1);
    // Store, clear the bypass, then restore applies it
    nvm_value = v;
    strap_detect_bypass = 1'b0;
    // A restore while the clock enable is low must not be taken
    ce = 1'b0;
    restore_all = 1'b1;
    host.step();
    restore_all = 1'b0;
    ce = 1'b1;
    host.step();
    check("pending", 40'(update_pending), 40'h1);
    hw_q.push_back(v);
    restore_all = 1'b1;
    host.step();
    restore_all = 1'b0;
    host.step();
    check("pending", 40'(update_pending), 40'h0);
    // Bias dropout and recovery reload the stored value
    v = rnd();
    wr(8'h05, v, 5);
    nvm_value = v;
    analog_bias_supply_low = 1'b1;
    repeat (3) host.step();
    // A write while the bias is low is refused; the reload wins
    wr(8'h05, rnd(), 5);
    hw_q.push_back(v);
    analog_bias_supply_low = 1'b0;
    repeat (3) host.step();
    // Malformed frames and a foreign command change nothing
    conversion_enabled = 1'b0;
    wr(8'h04, rnd(), 5);
    wr(8'h05, rnd(), 4);
    host.write_block(8'hb2, 8'h05, rnd(), 5);
    repeat (2) host.step();
    check("rejects", 40'(rejects), 40'h2);
    expect_read(v);
    host.read_block(8'hb1);
    repeat (3) host.step();
    check("left", 40'(hw_q.size() + rd_q.size()), 40'h0);
    print_verdict();
  end
endmodule

bind comp_cfg_regbank comp_cfg_assertions u_chk (.sys_clk, .rstn, .ce,
  .rd_byte_req, .restore_all, .analog_bias_supply_low, .init_ready,
  .conversion_enabled, .rd_byte_valid, .current_integrator_cap_code,
  .voltage_integrator_cap_code, .current_transconductance_code,
  .hw_update, .update_pending, .write_rejected, .init_done);
